// [rtl/event_timer_prescaler.sv]
// Event timer: 8-bit up-counter with shared 8-bit prescaler and overflow request
// What this block does
// RL1: Eight-bit event_timer is read and written like a file register, wraps after 256.
// RL2: Source is the event pin when clock_source_select is 1, else instruction cycles.
// RL3: Pin source counts rising edges if edge_select is 0, falling if 1.
// RL4: One 8-bit prescaler serves either the timer or the watchdog, never both.
// RL5: Counted ticks advance the prescaler; its selected bit's falling transitions advance the timer.
// RL6: Largest prescale factor is 256, giving a span of 65,536 counts.
// RL7: Each FFh to 00h wrap requests an interrupt while overflow_irq_mask_n is 0.
// RL8: Instruction-clock mode without prescaler advances the timer once per cycle.
// RL9: Software write loads the count; counting continues upward from it.
// RL10: Power-down stops the timer; contents after wakeup need not be kept.
// RL11: At most one external event counted per instruction cycle.
// RL12: Mask and w-map bits act only when option_extend_fuse is 0.
// RL13: Wrap sets overflow_pending, bit 7 of timer1_control_b, on the larger variant.
// RL14: Smaller variants lack the flag; software infers a wrap from a near-zero count.
// RL15: Accepted interrupt vectors to 0000h; return instructions resume the interrupted code.
// RL16: prescaler_assign 1 gives prescaler to watchdog; timer counts its source directly.
// RL17: divide_select 000 to 111 selects factors 2 through 256.
// RL18: Event pin is synchronised before edge detection; one pulse per qualifying edge.
`timescale 1ns/1ps

module event_timer_prescaler
  import event_timer_pkg::*;
#(
  parameter bit HAS_PENDING_FLAG = 1'b1
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Configuration and power state
  input  wire timer_cfg_t cfg,
  input  wire logic       power_down,
  // Core register access
  input  wire logic       count_wr,
  input  wire logic [7:0] count_wdata,
  input  wire logic       pending_clr,
  // Watchdog side of the shared prescaler
  input  wire logic       watchdog_tick,
  input  wire logic       watchdog_clear,
  // External event pin
  input  wire logic       event_pin,
  // Outputs
  output logic [7:0]      count_value,
  output logic            overflow_pending,
  output logic            overflow_irq,
  output logic            watchdog_timeout_tick,
  output logic            timer_w_map
);

  timer_state_t state_reg;
  timer_state_t state_next;

  logic       pin_edge;
  logic       src_tick;
  logic       pre_bit_old;
  logic       pre_bit_new;
  logic       timer_tick;
  logic [7:0] pre_inc;
  logic       mask_n_eff;
  logic       wd_tick_out;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    // Second flop only feeds the edge detector; first flop is never read elsewhere
    state_next.pin_meta = event_pin;                                     // RL18
    state_next.pin_sync = state_reg.pin_meta;                            // RL18
    state_next.pin_prev = state_reg.pin_sync;
    // One-cycle pulse per edge caps counting at one event per cycle
    pin_edge = cfg.edge_select ? (state_reg.pin_prev & ~state_reg.pin_sync)  // RL3 RL11
                               : (~state_reg.pin_prev & state_reg.pin_sync); // RL3 RL11
    src_tick = cfg.clock_source_select ? pin_edge : 1'b1;                // RL2 RL8
    // Prescaler ticks from the timer source or from the watchdog, never both
    pre_inc     = state_reg.prescale + 8'h01;                            // RL4
    pre_bit_old = state_reg.prescale[cfg.divide_select];                 // RL17
    pre_bit_new = pre_inc[cfg.divide_select];                            // RL17
    timer_tick  = 1'b0;
    wd_tick_out = 1'b0;
    if (cfg.prescaler_assign) begin
      timer_tick = src_tick;                                             // RL16
      if (watchdog_clear) begin
        state_next.prescale = PRESCALE_RESET;
      end else if (watchdog_tick) begin
        state_next.prescale = pre_inc;                                   // RL4
        // Carry out of the selected bit gives divide by 2..256 postscale
        wd_tick_out = pre_bit_old & ~pre_bit_new;
      end
    end else if (src_tick) begin
      state_next.prescale = pre_inc;                                     // RL5
      // Falling transition of bit n divides by 2^(n+1); bit 7 gives 256
      timer_tick = pre_bit_old & ~pre_bit_new;                           // RL5 RL6 RL17
    end
    mask_n_eff = cfg.option_extend_fuse | cfg.overflow_irq_mask_n;       // RL12
    state_next.map_w      = ~cfg.option_extend_fuse & cfg.timer_w_map_select; // RL12
    state_next.wrap_pulse = 1'b0;
    state_next.irq_req    = 1'b0;
    // Power-down freezes counting; the held value carries no promise after wakeup
    if (!power_down) begin                                               // RL10
      if (count_wr) begin
        // A write wins over a tick in the same cycle
        state_next.count = count_wdata;                                  // RL9
        if (count_wr && !cfg.prescaler_assign) begin
          state_next.prescale = PRESCALE_RESET;
        end
      end else if (timer_tick) begin
        state_next.count = state_reg.count + 8'h01;                      // RL1
        if (state_reg.count == COUNT_WRAP) begin
          state_next.wrap_pulse = 1'b1;
          state_next.irq_req    = ~mask_n_eff;                           // RL7
        end
      end
    end else begin
      state_next.prescale = cfg.prescaler_assign ? state_next.prescale : state_reg.prescale;
    end
    // Set wins over the clear
    if (pending_clr) begin
      state_next.overflow_pending = 1'b0;
    end
    if (HAS_PENDING_FLAG && state_next.wrap_pulse) begin
      state_next.overflow_pending = 1'b1;                                // RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                  <= '0;
      state_reg.count            <= COUNT_RESET;
      state_reg.prescale         <= PRESCALE_RESET;
      watchdog_timeout_tick      <= 1'b0;
    end else begin
      state_reg             <= state_next;
      watchdog_timeout_tick <= wd_tick_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops

  // The core vectors to 0000h on overflow_irq and restores context on return
  assign count_value      = state_reg.count;                             // RL1 RL15
  assign overflow_pending = state_reg.overflow_pending;                  // RL13 RL14
  assign overflow_irq     = state_reg.irq_req;                           // RL7 RL15
  assign timer_w_map      = state_reg.map_w;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_wrap_irq;
    @(posedge clock) disable iff (!rst_n)
      (!power_down && !count_wr && timer_tick && state_reg.count == COUNT_WRAP
       && !cfg.option_extend_fuse && !cfg.overflow_irq_mask_n)
      |=> overflow_irq && count_value == 8'h00;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap did not raise request"); // RL7

  property p_masked;
    @(posedge clock) disable iff (!rst_n)
      cfg.option_extend_fuse |=> !overflow_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("request with fuse set"); // RL12

  property p_load;
    @(posedge clock) disable iff (!rst_n)
      (count_wr && !power_down) |=> count_value == $past(count_wdata);
  endproperty
  a_load: assert property (p_load) else $error("write not loaded"); // RL9

  property p_direct;
    @(posedge clock) disable iff (!rst_n)
      (!power_down && !count_wr && !cfg.clock_source_select && cfg.prescaler_assign)
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_direct: assert property (p_direct) else $error("no step per cycle"); // RL8

  property p_frozen;
    @(posedge clock) disable iff (!rst_n)
      power_down |=> count_value == $past(count_value);
  endproperty
  a_frozen: assert property (p_frozen) else $error("counted in power-down"); // RL10

  property p_edge_once;
    @(posedge clock) disable iff (!rst_n)
      pin_edge |=> !pin_edge;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge pulse too long"); // RL11

  property p_rise;
    @(posedge clock) disable iff (!rst_n)
      (!cfg.edge_select && pin_edge) |-> state_reg.pin_sync && !state_reg.pin_prev;
  endproperty
  a_rise: assert property (p_rise) else $error("wrong edge sensed"); // RL3

  property p_pending;
    @(posedge clock) disable iff (!rst_n)
      (HAS_PENDING_FLAG && state_reg.wrap_pulse) |-> overflow_pending;
  endproperty
  a_pending: assert property (p_pending) else $error("pending not set"); // RL13

  property p_presc_div;
    @(posedge clock) disable iff (!rst_n)
      (!power_down && !count_wr && !cfg.prescaler_assign && cfg.divide_select == DIVIDE_MAX
       && src_tick && state_reg.prescale != 8'hff)
      |=> count_value == $past(count_value);
  endproperty
  a_presc_div: assert property (p_presc_div) else $error("divide by 256 broken"); // RL6

  // Flag, request and mapping outputs
  property p_irq_pulse;
    @(posedge clock) disable iff (!rst_n)
      overflow_irq |=> !overflow_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request longer than one cycle"); // RL7

  property p_pend_hold;
    @(posedge clock) disable iff (!rst_n)
      (overflow_pending && !pending_clr) |=> overflow_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped without clear"); // RL13

  property p_pend_clear;
    @(posedge clock) disable iff (!rst_n)
      (pending_clr && !state_next.wrap_pulse) |=> !overflow_pending;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared"); // RL13

  property p_wmap_off;
    @(posedge clock) disable iff (!rst_n)
      cfg.option_extend_fuse |=> !timer_w_map;
  endproperty
  a_wmap_off: assert property (p_wmap_off) else $error("w map active with fuse set"); // RL12

  property p_wmap_on;
    @(posedge clock) disable iff (!rst_n)
      (!cfg.option_extend_fuse && cfg.timer_w_map_select) |=> timer_w_map;
  endproperty
  a_wmap_on: assert property (p_wmap_on) else $error("w map not active"); // RL12

  // Prescaler routing, counting and pin edge sensing
  property p_presc_hold;
    @(posedge clock) disable iff (!rst_n)
      (!cfg.prescaler_assign && !power_down && !count_wr && !src_tick)
      |=> count_value == $past(count_value);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("step without source tick"); // RL5

  property p_wd_quiet;
    @(posedge clock) disable iff (!rst_n)
      !cfg.prescaler_assign |=> !watchdog_timeout_tick;
  endproperty
  a_wd_quiet: assert property (p_wd_quiet) else $error("watchdog tick while timer owns"); // RL4

  property p_wr_clear;
    @(posedge clock) disable iff (!rst_n)
      (count_wr && !power_down && !cfg.prescaler_assign) |=> state_reg.prescale == PRESCALE_RESET;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write left prescaler set"); // RL9

  property p_fall;
    @(posedge clock) disable iff (!rst_n)
      (cfg.edge_select && pin_edge) |-> !state_reg.pin_sync && state_reg.pin_prev;
  endproperty
  a_fall: assert property (p_fall) else $error("wrong falling edge sensed"); // RL3

  property p_pin_src;
    @(posedge clock) disable iff (!rst_n)
      (cfg.clock_source_select && !pin_edge) |-> !src_tick;
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("tick without pin edge"); // RL2

  property p_div_step;
    @(posedge clock) disable iff (!rst_n)
      (!power_down && !count_wr && !cfg.prescaler_assign && cfg.divide_select == DIVIDE_MAX
       && src_tick && state_reg.prescale == 8'hff)
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_div_step: assert property (p_div_step) else $error("no step after 256 ticks"); // RL6

  property p_wd_post;
    @(posedge clock) disable iff (!rst_n)
      (cfg.prescaler_assign && watchdog_tick && !watchdog_clear && cfg.divide_select == 3'h0
       && state_reg.prescale[0])
      |=> watchdog_timeout_tick;
  endproperty
  a_wd_post: assert property (p_wd_post) else $error("postscaler tick missing"); // RL4

  property p_tick_src;
    @(posedge clock) disable iff (!rst_n)
      (cfg.prescaler_assign && !power_down && !count_wr && src_tick)
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("direct tick not counted"); // RL16

  property p_pd_wr;
    @(posedge clock) disable iff (!rst_n)
      (power_down && count_wr) |=> count_value == $past(count_value);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("write taken in power-down"); // RL10

  property p_wd_clear;
    @(posedge clock) disable iff (!rst_n)
      (cfg.prescaler_assign && watchdog_clear) |=> state_reg.prescale == PRESCALE_RESET;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear ignored"); // RL4

endmodule : event_timer_prescaler

// [rtl/event_timer_pkg.sv]
// Package: constants and carrier types for the event timer with shared prescaler
package event_timer_pkg;

  // Reset values, wrap point and largest divide select
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] COUNT_WRAP     = 8'hff;
  localparam logic [2:0] DIVIDE_RESET   = 3'h7;
  localparam logic [2:0] DIVIDE_MAX     = 3'h7;

  // Bit position of the pending flag inside the timer1 control B byte
  localparam int PENDING_BIT = 7;

  // Configuration carried from the option and fuse bits
  typedef struct packed {
    logic       clock_source_select;
    logic       edge_select;
    logic       prescaler_assign;
    logic [2:0] divide_select;
    logic       overflow_irq_mask_n;
    logic       timer_w_map_select;
    logic       option_extend_fuse;
  } timer_cfg_t;

  // State of the block apart from the watchdog timeout flop
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] prescale;
    logic       pin_meta;
    logic       pin_sync;
    logic       pin_prev;
    logic       irq_req;
    logic       overflow_pending;
    logic       wrap_pulse;
    logic       map_w;
  } timer_state_t;

endpackage : event_timer_pkg

// [bench/event_source_model.sv]
// Partner model: external pulse source that drives the event pin
`timescale 1ns/1ps

module event_source_model (
  // Event pin
  output logic event_pin
);
  initial event_pin = 1'b0;

  // Optional glitches first, then each level is held long enough to cross the synchroniser
  task automatic step(input logic level, input int glitches);
    repeat (glitches) begin
      event_pin = level;
      #5;
      event_pin = ~level;
      #5;
    end
    event_pin = level;
    #120;
  endtask
endmodule // event_source_model

// [bench/event_timer_prescaler_bench.sv]
// Testbench: event timer counting, prescaling, wrap flags, power-down
`timescale 1ns/1ps

module event_timer_prescaler_bench
  import event_timer_pkg::*;
;
  logic        clock, rst_n, power_down, count_wr, pending_clr, event_pin, strict, pend_exp;
  logic [7:0]  count_wdata, count_value, cnt, last_count;
  logic        overflow_pending, overflow_irq, timer_w_map, wd_tick, wd_clear, wd_timeout;
  logic [10:0] notes[$];
  logic [10:0] seen;
  timer_cfg_t  cfg;
  int          err_total = 0;
  int          tests_run = 0;

  event_timer_prescaler DUT (.clock(clock), .rst_n(rst_n), .cfg(cfg), .power_down(power_down),
    .count_wr(count_wr), .count_wdata(count_wdata), .pending_clr(pending_clr),
    .watchdog_tick(wd_tick), .watchdog_clear(wd_clear), .event_pin(event_pin),
    .count_value(count_value), .overflow_pending(overflow_pending),
    .overflow_irq(overflow_irq), .watchdog_timeout_tick(wd_timeout), .timer_w_map(timer_w_map));
  event_source_model src (.event_pin(event_pin));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value timer_state expected %h seen %h", exp, got);
    end
  endtask

  // Note layout: w-map, pending, irq, count
  task automatic note(input logic [7:0] c);
    logic irq;
    irq = (c == 8'h00) && !cfg.overflow_irq_mask_n && !cfg.option_extend_fuse;
    if (c == 8'h00) pend_exp = 1'b1;
    notes.push_back({cfg.timer_w_map_select & ~cfg.option_extend_fuse, pend_exp, irq, c});
  endtask

  task automatic write(input logic [7:0] v);
    @(negedge clock);
    count_wdata = v;
    count_wr = 1'b1;
    @(negedge clock);
    count_wr = 1'b0;
  endtask

  task automatic drain(input int n);
    for (int k = 0; k < n && notes.size() > 0; k++) @(negedge clock);
    repeat (6) @(negedge clock);
    if (notes.size() != 0) begin
      err_total++;
      $display("wrong value notes_left expected 0 seen %0d", notes.size());
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Any count change is a result; an unexpected one is an error while strict
  always @(negedge clock) begin
    seen = {timer_w_map, overflow_pending, overflow_irq, count_value};
    if (rst_n && count_value !== last_count) begin
      if (notes.size() > 0) check(notes.pop_front(), seen);
      else if (strict) check({seen[10:8], last_count}, seen);
    end
    last_count = count_value;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    rst_n = 1'b0;
    cfg = '0;
    cfg.clock_source_select = 1'b1;
    cfg.prescaler_assign = 1'b1;
    {power_down, count_wr, count_wdata, pending_clr, pend_exp, cnt, wd_tick, wd_clear} = '0;
    strict = 1'b1;
    void'($urandom(32'hd0713c46));
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    check({3'b000, COUNT_RESET}, {timer_w_map, overflow_pending, overflow_irq, count_value});
    for (int e = 0; e < 2; e++) begin
      cfg.edge_select = e[0];
      for (int l = 1; l >= 0; l--) begin
        if (l != e) begin
          cnt++;
          note(cnt);
        end
        src.step(l[0], 0);
        drain(8);
      end
    end
    cnt++;
    note(cnt);
    src.step(1'b1, 2);
    src.step(1'b0, 0);
    drain(8);
    // Mask and fuse gate the request, the fuse also the w-map, never the pending flag
    for (int m = 0; m < 3; m++) begin
      cfg.overflow_irq_mask_n = (m == 1);
      cfg.option_extend_fuse = (m == 2);
      cfg.timer_w_map_select = 1'b1;
      @(negedge clock);
      pending_clr = 1'b1;
      @(negedge clock);
      pending_clr = 1'b0;
      pend_exp = 1'b0;
      cnt = 8'hfe - 8'($urandom % 4);
      note(cnt);
      write(cnt);
      while (cnt != 8'h00) begin
        cnt++;
        note(cnt);
        src.step(1'b1, 0);
        src.step(1'b0, 0);
      end
      drain(8);
    end
    cfg.prescaler_assign = 1'b0;
    for (int d = 0; d < 8; d++) begin
      cfg.divide_select = d[2:0];
      cnt = 8'h10 + 8'(d * 32);
      note(cnt);
      write(cnt);
      for (int p = 1; p <= (4 << d); p++) begin
        if (p % (2 << d) == 0) begin
          cnt++;
          note(cnt);
        end
        src.step(1'b1, 0);
        src.step(1'b0, 0);
      end
      drain(8);
    end
    cfg.prescaler_assign = 1'b1;
    power_down = 1'b1;
    cfg.clock_source_select = 1'b0;
    write(8'h55);
    repeat (20) @(negedge clock);
    repeat (16) begin
      cnt++;
      note(cnt);
    end
    power_down = 1'b0;
    // Exactly 16 free-running cycles, then the idle pin takes over so counting stops
    repeat (16) @(negedge clock);
    cfg.clock_source_select = 1'b1;
    @(negedge clock);
    check({3'b000, cnt}, {3'b000, count_value});
    // Watchdog owns the prescaler: at divide 2, eight ticks give four timeout pulses
    cfg.divide_select = 3'h0;
    wd_clear = 1'b1;
    @(negedge clock);
    wd_clear = 1'b0;
    wd_tick = 1'b1;
    k = 0;
    repeat (8) begin
      @(negedge clock);
      k += int'(wd_timeout === 1'b1);
    end
    wd_tick = 1'b0;
    check({3'b000, 8'(k)}, 11'h004);
    drain(2);
    stop_test();
  end
endmodule // event_timer_prescaler_bench
